/* File: src/cluster_pkg.sv */
// Purpose : Shared constants for the cluster brightness register link
// Assumes : One clock; both ends sit on the same clock
// Notes   : Offsets are 10-bit register addresses, data is 16 bits
package cluster_pkg;

    // ========================================================
    // Register offsets
    localparam logic [9:0] OFS_SOURCE_SELECT = 10'h020; // Source select
    localparam logic [9:0] OFS_GLOBAL_BRT    = 10'h028; // Global level
    localparam logic [9:0] OFS_MAP_A         = 10'h030; // Drivers 0..3
    localparam logic [9:0] OFS_MAP_B         = 10'h032; // Drivers 4..5
    localparam logic [9:0] OFS_STAGED_CTRL   = 10'h178; // Load bit
    localparam logic [9:0] OFS_DRIVER_CFG    = 10'h17a; // Power/short bits
    localparam logic [9:0] OFS_DUTY_DIAG     = 10'h2a8; // Driver 0 duty
    localparam logic [9:0] OFS_CURR_DIAG     = 10'h2aa; // Driver 0 current
    // Group brightness 1..5, entry 0 is group 1
    localparam logic [4:0][9:0] OFS_GROUP_BRT =
        {10'h16c, 10'h160, 10'h154, 10'h148, 10'h13c};
    // Driver current 0..5
    localparam logic [5:0][9:0] OFS_CURRENT =
        {10'h1cc, 10'h1ca, 10'h1c8, 10'h1c6, 10'h1c4, 10'h1c2};
    // Storage-only registers
    localparam int          NUM_PLAIN = 10;
    localparam logic [9:0][9:0] OFS_PLAIN =
        {10'h28a, 10'h288, 10'h0ee, 10'h0ec, 10'h052,
         10'h050, 10'h04e, 10'h042, 10'h040, 10'h054};
    // Read-only, read as zero
    localparam logic [5:0][9:0] OFS_READ_ZERO =
        {10'h2ac, 10'h2a6, 10'h2a4, 10'h0e8, 10'h058, 10'h056};

    // ========================================================
    // Reset values and fields
    localparam logic [15:0] RST_SOURCE_SELECT = 16'h0300; // Source select
    localparam logic [15:0] RST_ZERO          = 16'h0000; // Others
    localparam logic [1:0]  MODE_PWM_PIN      = 2'h0;     // Pin duty
    localparam logic [1:0]  MODE_GLOBAL_REG   = 2'h2;     // Global reg
    localparam logic [1:0]  MODE_RSVD_A       = 2'h1;     // Reserved
    localparam logic [1:0]  MODE_RSVD_B       = 2'h3;     // Reserved
    localparam int          LOAD_BIT          = 0;        // Staged load
    localparam int          POWER_LSB         = 0;        // Outside power
    localparam int          SHORT_LSB         = 8;        // Short detect off
    localparam int          MAP_W             = 4;        // Map field width
    localparam int          CUR_W             = 12;       // Current width
    localparam int          NUM_DRV           = 6;        // Drivers
    localparam int          NUM_GRP           = 5;        // Groups
    localparam logic [3:0]  MAP_BASE          = 4'h0;     // Base source
    localparam logic [3:0]  MAP_LAST_GRP      = 4'h5;     // Last group code

    // ========================================================
    // Link framing
    localparam int          RD_FLAG_BIT       = 7;        // Read in byte 0

    // True for offsets that appear in the register map
    function automatic logic is_mapped(input logic [9:0] a);
        logic hit;
        hit = (a == OFS_SOURCE_SELECT) || (a == OFS_GLOBAL_BRT) ||
              (a == OFS_MAP_A) || (a == OFS_MAP_B) ||
              (a == OFS_STAGED_CTRL) || (a == OFS_DRIVER_CFG) ||
              (a == OFS_DUTY_DIAG) || (a == OFS_CURR_DIAG);
        for (int k = 0; k < NUM_GRP; k++)
            hit = hit || (a == OFS_GROUP_BRT[k]);
        for (int k = 0; k < NUM_DRV; k++)
            hit = hit || (a == OFS_CURRENT[k]) || (a == OFS_READ_ZERO[k]);
        for (int k = 0; k < NUM_PLAIN; k++)
            hit = hit || (a == OFS_PLAIN[k]);
        return hit;
    endfunction

endpackage

/* File: src/cluster_link_if.sv */
// Purpose : Byte link between register host and cluster device
// Assumes : Both ends clocked by the same CLK
// Notes   : sel frames one access, byte_vld marks a host byte
`timescale 1ns/1ps
interface cluster_link_if;
    logic       sel;      // Frame active, host driven
    logic       byte_vld; // Host byte valid, one cycle
    logic [7:0] byte_dat; // Host byte
    logic       resp_vld; // Device byte valid, one cycle
    logic [7:0] resp_dat; // Device byte

    modport dev (input sel, input byte_vld, input byte_dat,
                 output resp_vld, output resp_dat);
    modport hst (output sel, output byte_vld, output byte_dat,
                 input resp_vld, input resp_dat);
endinterface

/* File: src/cluster_device.sv */
// Purpose : Cluster brightness and current register bank
// Assumes : Host frames each access as address then two data bytes
// Notes   : Group brightness and currents are staged until load
//
// Overview of operation
// - Each driver gets own duty and current
// - Boost feedback uses drivers not outside powered
// - Host marks outside-powered strings with one
// - Six outside power bits, one per driver
// - Per-driver map picks base (pin or global) or group brightness
// - Five sixteen-bit group brightness registers
// - Six twelve-bit current scale values
// - Load bit applies staged values together
// - Six bits suppress short detection per driver
// - Host disables short detect for dimmer strings
// - Source field zero pin, two register
// - Host never writes reserved source codes
// - Host leaves unmapped offsets untouched
// - Four-bit map, zero base, one-five groups
// - Access is address then two data bytes
`timescale 1ns/1ps
module cluster_device
(
    input  wire logic        CLK,             // Clock
    input  wire logic        RST,             // Sync reset, high
    cluster_link_if.dev      LINK,            // Host link
    input  wire logic [15:0] PWM_DUTY,        // Measured pin duty
    output logic [95:0]      DRIVER_DUTY,     // Six 16-bit duties
    output logic [71:0]      DRIVER_CURRENT,  // Six 12-bit currents
    output logic [5:0]       BOOST_FEEDBACK,  // Headroom feeds loop
    output logic [5:0]       OUTSIDE_POWER,   // Outside supplied
    output logic [5:0]       SHORT_DETECT_EN  // Short detect armed
);

    // ========================================================
    // Types
    typedef enum logic [2:0]
    {
        ST_CMD = 3'b000, // Wait first byte
        ST_ADR = 3'b001, // Wait address byte
        ST_DHI = 3'b010, // Wait data high
        ST_DLO = 3'b011, // Wait data low
        ST_RHI = 3'b100, // Send read high
        ST_RLO = 3'b101  // Send read low
    } phase_type;

    typedef struct packed
    {
        phase_type          st;        // Link phase
        logic               rd;
        logic [1:0]         page;      // Upper address bits
        logic [9:0]         addr;
        logic [7:0]         hi;        // Held data high byte
        logic               resp_vld;
        logic [7:0]         resp_dat;
        logic [15:0]        src_sel;
        logic [15:0]        glob;
        logic [31:0]        map;       // Map b over map a
        logic [15:0]        drv_cfg;   // Power and short bits
        logic [4:0][15:0]   grp_stg;   // Staged group levels
        logic [4:0][15:0]   grp_act;   // Applied group levels
        logic [5:0][11:0]   cur_stg;   // Staged currents
        logic [5:0][11:0]   cur_act;   // Applied currents
        logic [9:0][15:0]   plain;     // Storage only
        logic [5:0][15:0]   duty;
    } state_type;

    state_type s_r;   // Registered state
    state_type s_nxt; // Next state
    logic [15:0] rdata;   // Read mux
    logic        wr;      // Write strobe
    logic [15:0] wdata;   // Write data
    logic [15:0] base;    // Base brightness
    logic [3:0]  code;    // Map field of one driver

    // ========================================================
    // Read mux, staged values read back before load
    always_comb
    begin
        case (s_r.addr)
            cluster_pkg::OFS_SOURCE_SELECT: rdata = s_r.src_sel;
            cluster_pkg::OFS_GLOBAL_BRT:    rdata = s_r.glob;
            cluster_pkg::OFS_MAP_A:         rdata = s_r.map[15:0];
            cluster_pkg::OFS_MAP_B:         rdata = s_r.map[31:16];
            cluster_pkg::OFS_DRIVER_CFG:    rdata = s_r.drv_cfg;
            cluster_pkg::OFS_DUTY_DIAG:     rdata = s_r.duty[0];
            cluster_pkg::OFS_CURR_DIAG:     rdata = {4'h0, s_r.cur_act[0]};
            default:                        rdata = 16'h0000;
        endcase
        // Group, current and plain slots
        for (int g = 0; g < cluster_pkg::NUM_GRP; g++)
            if (s_r.addr == cluster_pkg::OFS_GROUP_BRT[g])
                rdata = s_r.grp_stg[g];
        for (int d = 0; d < cluster_pkg::NUM_DRV; d++)
            if (s_r.addr == cluster_pkg::OFS_CURRENT[d])
                rdata = {4'h0, s_r.cur_stg[d]};
        for (int p = 0; p < cluster_pkg::NUM_PLAIN; p++)
            if (s_r.addr == cluster_pkg::OFS_PLAIN[p])
                rdata = s_r.plain[p];
    end

    // ========================================================
    // Link, writes and duties
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.resp_vld = 1'b0;
        wr = 1'b0;
        wdata = {s_r.hi, LINK.byte_dat};
        base = 16'h0000;
        code = 4'h0;
        // Dropping the frame abandons any partial access
        if (!LINK.sel)
        begin
            s_nxt.st = ST_CMD;
        end
        else
        begin
            case (s_r.st)
                ST_CMD:
                begin
                    // First byte: read flag and page
                    if (LINK.byte_vld)
                    begin
                        s_nxt.rd = LINK.byte_dat[cluster_pkg::RD_FLAG_BIT];
                        s_nxt.page = LINK.byte_dat[1:0];
                        s_nxt.st = ST_ADR;
                    end
                end
                ST_ADR:
                begin
                    // Address byte, then data or answer
                    if (LINK.byte_vld)
                    begin
                        s_nxt.addr = {s_r.page, LINK.byte_dat};
                        s_nxt.st = s_r.rd ? ST_RHI : ST_DHI;
                    end
                end
                ST_DHI:
                begin
                    // High byte goes first
                    if (LINK.byte_vld)
                    begin
                        s_nxt.hi = LINK.byte_dat;
                        s_nxt.st = ST_DLO;
                    end
                end
                ST_DLO:
                begin
                    // Low byte completes the write
                    if (LINK.byte_vld)
                    begin
                        wr = 1'b1;
                        s_nxt.st = ST_CMD;
                    end
                end
                ST_RHI:
                begin
                    // Answer high byte
                    s_nxt.resp_vld = 1'b1;
                    s_nxt.resp_dat = rdata[15:8];
                    s_nxt.st = ST_RLO;
                end
                ST_RLO:
                begin
                    // Answer low byte
                    s_nxt.resp_vld = 1'b1;
                    s_nxt.resp_dat = rdata[7:0];
                    s_nxt.st = ST_CMD;
                end
                default:
                begin
                    s_nxt.st = ST_CMD;
                end
            endcase
        end
        // Register writes; unmapped offsets are ignored
        if (wr)
        begin
            case (s_r.addr)
                cluster_pkg::OFS_SOURCE_SELECT: s_nxt.src_sel = wdata;
                cluster_pkg::OFS_GLOBAL_BRT:    s_nxt.glob = wdata;
                cluster_pkg::OFS_MAP_A:         s_nxt.map[15:0] = wdata;
                cluster_pkg::OFS_MAP_B:         s_nxt.map[31:16] = wdata;
                cluster_pkg::OFS_DRIVER_CFG:    s_nxt.drv_cfg = wdata;
                default:                        ;
            endcase
            for (int g = 0; g < cluster_pkg::NUM_GRP; g++)
                if (s_r.addr == cluster_pkg::OFS_GROUP_BRT[g])
                    s_nxt.grp_stg[g] = wdata;
            for (int d = 0; d < cluster_pkg::NUM_DRV; d++)
                if (s_r.addr == cluster_pkg::OFS_CURRENT[d])
                    s_nxt.cur_stg[d] = wdata[11:0];
            for (int p = 0; p < cluster_pkg::NUM_PLAIN; p++)
                if (s_r.addr == cluster_pkg::OFS_PLAIN[p])
                    s_nxt.plain[p] = wdata;
            // Load bit is a strobe, nothing is stored
            if (s_r.addr == cluster_pkg::OFS_STAGED_CTRL &&
                wdata[cluster_pkg::LOAD_BIT])
            begin
                s_nxt.grp_act = s_r.grp_stg;
                s_nxt.cur_act = s_r.cur_stg;
            end
        end
        // Base level; reserved codes fall back to the pin
        if (s_r.src_sel[1:0] == cluster_pkg::MODE_GLOBAL_REG)
            base = s_r.glob;
        else
            base = PWM_DUTY;
        // Per-driver source; codes above five use the base level
        for (int d = 0; d < cluster_pkg::NUM_DRV; d++)
        begin
            code = s_r.map[d*cluster_pkg::MAP_W +: cluster_pkg::MAP_W];
            if (code == cluster_pkg::MAP_BASE ||
                code > cluster_pkg::MAP_LAST_GRP)
                s_nxt.duty[d] = base;
            else
                s_nxt.duty[d] = s_r.grp_act[code - 4'h1];
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s_r <= '0;
            s_r.st <= ST_CMD;
            s_r.src_sel <= cluster_pkg::RST_SOURCE_SELECT;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ========================================================
    // Outputs from flip-flops; boost feedback and short enables go through inverters
    assign LINK.resp_vld = s_r.resp_vld;
    assign LINK.resp_dat = s_r.resp_dat;
    assign DRIVER_DUTY = s_r.duty;
    assign DRIVER_CURRENT = s_r.cur_act;
    // Outside powered strings have no say in the boost voltage
    assign OUTSIDE_POWER = s_r.drv_cfg[cluster_pkg::POWER_LSB +: 6];
    assign BOOST_FEEDBACK = ~s_r.drv_cfg[cluster_pkg::POWER_LSB +: 6];
    assign SHORT_DETECT_EN = ~s_r.drv_cfg[cluster_pkg::SHORT_LSB +: 6];

endmodule // cluster_device

/* File: src/cluster_host.sv */
// Purpose : Host end that turns register requests into link frames
// Assumes : Device shares CLK and answers reads two cycles on
// Notes   : Reserved source codes and unmapped writes are refused
`timescale 1ns/1ps
module cluster_host
(
    input  wire logic        CLK,         // Clock
    input  wire logic        RST,         // Sync reset, high
    cluster_link_if.hst      LINK,        // Device link
    input  wire logic        REQ,         // Request pulse
    input  wire logic        REQ_WRITE,   // One for write
    input  wire logic [9:0]  REQ_ADDR,    // Register offset
    input  wire logic [15:0] REQ_DATA,    // Write data
    output logic             BUSY,        // Access in progress
    output logic             REFUSED,     // Request dropped, pulse
    output logic             RESP_VALID,  // Read data, pulse
    output logic [15:0]      RESP_DATA    // Read data
);

    // ========================================================
    // Types
    typedef enum logic [1:0]
    {
        H_IDLE = 2'b00, // Frame closed
        H_SEND = 2'b01, // Shifting bytes out
        H_WAIT = 2'b10  // Collecting answer
    } hphase_type;

    typedef struct packed
    {
        hphase_type  st;      // Phase
        logic [31:0] bytes;   // Outgoing bytes, top first
        logic [1:0]  left;    // Bytes left minus one
        logic        rd;
        logic        got_hi;  // High answer byte seen
        logic        sel;
        logic        vld;
        logic [7:0]  dat;
        logic        refused; // Refusal pulse
        logic        rvalid;  // Answer pulse
        logic [15:0] rdata;   // Answer data
    } hstate_type;

    hstate_type h_r;   // Registered state
    hstate_type h_nxt; // Next state
    logic       bad;   // Request must not go out

    // ========================================================
    // Request screening and byte sequencing
    always_comb
    begin
        h_nxt = h_r;
        h_nxt.vld = 1'b0;
        h_nxt.refused = 1'b0;
        h_nxt.rvalid = 1'b0;
        bad = 1'b0;
        case (h_r.st)
            H_IDLE:
            begin
                h_nxt.sel = 1'b0;
                // Writes only go to mapped offsets and legal codes
                bad = REQ_WRITE && (!cluster_pkg::is_mapped(REQ_ADDR)
                      || (REQ_ADDR == cluster_pkg::OFS_SOURCE_SELECT &&
                          (REQ_DATA[1:0] == cluster_pkg::MODE_RSVD_A ||
                           REQ_DATA[1:0] == cluster_pkg::MODE_RSVD_B)));
                if (REQ && bad)
                begin
                    h_nxt.refused = 1'b1;
                end
                else if (REQ)
                begin
                    h_nxt.bytes = {~REQ_WRITE, 5'h00, REQ_ADDR[9:8],
                                   REQ_ADDR[7:0], REQ_DATA};
                    h_nxt.left = REQ_WRITE ? 2'd3 : 2'd1;
                    h_nxt.rd = ~REQ_WRITE;
                    h_nxt.got_hi = 1'b0;
                    h_nxt.st = H_SEND;
                end
            end
            H_SEND:
            begin
                // One byte a cycle with the frame held open
                h_nxt.sel = 1'b1;
                h_nxt.vld = 1'b1;
                h_nxt.dat = h_r.bytes[31:24];
                h_nxt.bytes = {h_r.bytes[23:0], 8'h00};
                h_nxt.left = h_r.left - 2'd1;
                if (h_r.left == 2'd0)
                    h_nxt.st = h_r.rd ? H_WAIT : H_IDLE;
            end
            H_WAIT:
            begin
                // High byte comes first, frame closes after low
                if (LINK.resp_vld && !h_r.got_hi)
                begin
                    h_nxt.rdata[15:8] = LINK.resp_dat;
                    h_nxt.got_hi = 1'b1;
                end
                else if (LINK.resp_vld)
                begin
                    h_nxt.rdata[7:0] = LINK.resp_dat;
                    h_nxt.rvalid = 1'b1;
                    h_nxt.st = H_IDLE;
                end
            end
            default:
            begin
                h_nxt.st = H_IDLE;
            end
        endcase
    end

    // ========================================================
    // State register
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            h_r <= '0;
            h_r.st <= H_IDLE;
        end
        else
        begin
            h_r <= h_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign LINK.sel = h_r.sel;
    assign LINK.byte_vld = h_r.vld;
    assign LINK.byte_dat = h_r.dat;
    assign BUSY = (h_r.st != H_IDLE) || h_r.sel;
    assign REFUSED = h_r.refused;
    assign RESP_VALID = h_r.rvalid;
    assign RESP_DATA = h_r.rdata;

endmodule // cluster_host

/* File: testbench/cluster_link_properties.sv */
// Purpose : Frame checks on the cluster register link
// Assumes : One clock, synchronous reset high
// Notes   : Watches only the interface signals
`timescale 1ns/1ps
module cluster_link_properties
(
    input wire logic       CLK,      // Clock
    input wire logic       RST,      // Sync reset
    input wire logic       sel,      // Frame open
    input wire logic       byte_vld, // Host byte valid
    input wire logic [7:0] byte_dat, // Host byte
    input wire logic       resp_vld, // Device byte valid
    input wire logic [7:0] resp_dat  // Device byte
);
    // ==========================================================
    // Frame shape
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    vld_in_frame_a: assert property (byte_vld |-> sel)
        else $error("host byte outside frame");
    resp_in_frame_a: assert property (resp_vld |-> sel)
        else $error("device byte outside frame");
    frame_head_a: assert property ($rose(sel) |-> byte_vld
        && byte_dat[6:2] == 5'h00) else $error("bad first byte");
    // Write: four bytes, then close
    write_frame_a: assert property ($rose(sel) && !byte_dat[7]
        |-> byte_vld[*4] ##1 !sel) else $error("bad write frame");
    // Read: two host bytes, one gap, two answer bytes
    read_frame_a: assert property ($rose(sel) && byte_dat[7]
        |-> byte_vld ##1 byte_vld ##1 !byte_vld && !resp_vld
        ##1 resp_vld ##1 resp_vld ##2 !sel)
        else $error("bad read frame");
    frame_bound_a: assert property ($rose(sel) |-> ##[1:6] !sel)
        else $error("frame too long");
    resp_cause_a: assert property (resp_vld
        |-> $past(byte_vld, 2) || $past(resp_vld))
        else $error("answer without request");
    // Unmapped offset 0x100 must read back as zero
    unmapped_zero_a: assert property ($rose(sel)
        && byte_dat == 8'h81 ##1 byte_dat == 8'h00
        |-> ##2 resp_dat == 8'h00 ##1 resp_dat == 8'h00)
        else $error("unmapped read not zero");
    reset_idle_a: assert property ($fell(RST)
        |-> !sel && !resp_vld) else $error("link busy after reset");
endmodule // cluster_link_properties

/* File: testbench/cluster_brightness_regs_tb.sv */
// Purpose : Host and device joined, checked against a register model
// Assumes : Host end turns requests into link frames
// Notes   : Levels and currents only move on the load bit
`timescale 1ns/1ps
module cluster_brightness_regs_tb;
    logic        CLK, RST;           // Clock, reset
    logic        req, req_write;     // Request strobe, write flag
    logic [9:0]  req_addr;           // Offset
    logic [15:0] req_data, pwm_duty; // Write data, pin duty
    logic        busy, refused, resp_valid; // Host status
    logic [15:0] resp_data, rd;      // Read data, last read
    logic [95:0] duty;               // Driver duties
    logic [71:0] cur;                // Applied currents
    logic [5:0]  boost, outside, shen; // Per-driver bits
    logic [31:0] lfsr;               // Random source
    logic        ref_seen;           // Refusal seen
    logic [15:0] mdl [int];          // Register model
    logic [15:0] grp_app [5] = '{default: '0}; // Applied levels
    logic [15:0] cur_app [6] = '{default: '0}; // Applied currents
    int          error_cnt, checks;  // Counters
    cluster_link_if link ();
    cluster_device cluster_device_inst (.CLK(CLK), .RST(RST), .LINK(link),
        .PWM_DUTY(pwm_duty), .DRIVER_DUTY(duty), .DRIVER_CURRENT(cur),
        .BOOST_FEEDBACK(boost), .OUTSIDE_POWER(outside),
        .SHORT_DETECT_EN(shen));
    cluster_host cluster_host_inst (.CLK(CLK), .RST(RST), .LINK(link),
        .REQ(req), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_DATA(req_data), .BUSY(busy), .REFUSED(refused),
        .RESP_VALID(resp_valid), .RESP_DATA(resp_data));
    cluster_link_properties chk_inst (.CLK(CLK), .RST(RST),
        .sel(link.sel), .byte_vld(link.byte_vld), .byte_dat(link.byte_dat),
        .resp_vld(link.resp_vld), .resp_dat(link.resp_dat));

    // ==========================================================
    // Helpers
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction
    function automatic logic [15:0] exp_rd(input logic [9:0] a);
        if (mdl.exists(int'(a)))
            return mdl[int'(a)];
        return 16'h0000; // Unmapped reads zero
    endfunction
    // Expected duty: group level, else global or pin by mode
    function automatic logic [15:0] exp_duty(input int d);
        logic [31:0] m;
        m = {exp_rd(cluster_pkg::OFS_MAP_B), exp_rd(cluster_pkg::OFS_MAP_A)};
        if (m[4*d+:4] >= 4'h1 && m[4*d+:4] <= 4'h5)
            return grp_app[m[4*d+:4] - 4'h1];
        if (mdl[int'(cluster_pkg::OFS_SOURCE_SELECT)][1:0] == 2'h2)
            return exp_rd(cluster_pkg::OFS_GLOBAL_BRT);
        return pwm_duty;
    endfunction
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    // One access, bounded wait
    task automatic acc(input logic w, input logic [9:0] a,
                       input logic [15:0] d, input logic er);
        int n;
        bit got;
        @(posedge CLK);
        req <= 1'b1; req_write <= w; req_addr <= a; req_data <= d;
        ref_seen = 1'b0; n = 0; got = 1'b0;
        do
        begin
            @(posedge CLK);
            req <= 1'b0;
            #1 n++;
            if (refused === 1'b1) ref_seen = 1'b1;
            if (resp_valid === 1'b1) rd = resp_data;
            got |= (resp_valid === 1'b1);
        end while (n < 12 && !(busy === 1'b0 && (w || ref_seen || got)));
        if (n >= 12) chk("access done", 16'h1, 16'h0);
        chk("refused", {15'h0, er}, {15'h0, ref_seen});
    endtask
    task automatic rdc(input logic [9:0] a);
        acc(1'b0, a, 16'h0000, 1'b0);
        chk("read", exp_rd(a), rd);
    endtask
    // Write and track it in the model
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        acc(1'b1, a, d, 1'b0);
        mdl[int'(a)] = d;
        for (int k = 0; k < 6; k++)
            if (a == cluster_pkg::OFS_CURRENT[k]) mdl[int'(a)] = d & 16'h0fff;
        if (a == cluster_pkg::OFS_STAGED_CTRL)
        begin
            mdl[int'(a)] = 16'h0000;
            for (int k = 0; k < 6 && d[0]; k++)
            begin
                cur_app[k] = exp_rd(cluster_pkg::OFS_CURRENT[k]);
                if (k < 5) grp_app[k] = exp_rd(cluster_pkg::OFS_GROUP_BRT[k]);
            end
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial
    begin
        repeat (5000) @(posedge CLK);
        error_cnt++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        RST = 1'b1; req = 1'b0; req_write = 1'b0; req_addr = 10'h000;
        req_data = 16'h0000; pwm_duty = 16'h1234; lfsr = 32'h148f10de;
        error_cnt = 0; checks = 0;
        mdl[int'(cluster_pkg::OFS_SOURCE_SELECT)] = 16'h0300;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        rdc(cluster_pkg::OFS_SOURCE_SELECT);
        chk("boost", 16'h003f, {10'h0, boost});
        // Staged currents must not reach outputs before load
        for (int k = 0; k < 5; k++) wr(cluster_pkg::OFS_GROUP_BRT[k], rnd());
        for (int k = 0; k < 6; k++) wr(cluster_pkg::OFS_CURRENT[k], rnd());
        for (int k = 0; k < 6; k++) chk("cur", 16'h0, {4'h0, cur[12*k+:12]});
        for (int k = 0; k < 6; k++) rdc(cluster_pkg::OFS_CURRENT[k]);
        for (int k = 0; k < 5; k++) rdc(cluster_pkg::OFS_GROUP_BRT[k]);
        wr(cluster_pkg::OFS_STAGED_CTRL, 16'h0001);
        repeat (2) @(posedge CLK);
        for (int k = 0; k < 6; k++) chk("cur", cur_app[k], {4'h0, cur[12*k+:12]});
        rdc(cluster_pkg::OFS_STAGED_CTRL);
        // Map codes 0 to 5 and 15 under both legal modes
        for (int m = 0; m < 4; m++)
        begin
            pwm_duty <= rnd();
            wr(cluster_pkg::OFS_SOURCE_SELECT, {14'h00c0, m[1], 1'b0});
            wr(cluster_pkg::OFS_GLOBAL_BRT, rnd());
            wr(cluster_pkg::OFS_MAP_A, m[0] ? 16'h1f45 : 16'h3210);
            wr(cluster_pkg::OFS_MAP_B, m[0] ? 16'h0032 : 16'h0054);
            repeat (3) @(posedge CLK);
            for (int d = 0; d < 6; d++) chk("duty", exp_duty(d), duty[16*d+:16]);
        end
        // Reserved codes and unmapped writes are refused
        acc(1'b1, cluster_pkg::OFS_SOURCE_SELECT, 16'h0301, 1'b1);
        acc(1'b1, cluster_pkg::OFS_SOURCE_SELECT, 16'h0303, 1'b1);
        acc(1'b1, 10'h100, rnd(), 1'b1);
        rdc(10'h100);
        rdc(cluster_pkg::OFS_SOURCE_SELECT);
        // Outside power and short detect bits
        for (int i = 0; i < 3; i++)
        begin
            req_data <= rnd() & 16'h3f3f;
            @(posedge CLK);
            wr(cluster_pkg::OFS_DRIVER_CFG, req_data);
            repeat (2) @(posedge CLK);
            chk("outside", {10'h0, req_data[5:0]}, {10'h0, outside});
            chk("short", {10'h0, ~req_data[13:8]}, {10'h0, shen});
            chk("boost", {10'h0, ~req_data[5:0]}, {10'h0, boost});
        end
        results();
    end
endmodule // cluster_brightness_regs_tb
